// File: hw/dimsp_consts.svh
`ifndef DIMSP_CONSTS_SVH
`define DIMSP_CONSTS_SVH
`define DIMSP_WORD_BITS      12
`define DIMSP_TWOS_FLIP      12'h800
`define DIMSP_CLK_PERIOD_NS  10
`define DIMSP_SCLK_HALF_NS   80
`define DIMSP_SCLK_HALF_CYC  ((`DIMSP_SCLK_HALF_NS + `DIMSP_CLK_PERIOD_NS - 1) / `DIMSP_CLK_PERIOD_NS)
`define DIMSP_RST_PULSE_CYC  4
`define DIMSP_INSTR_BITS     8
`define DIMSP_FRAME_BITS     16
`define DIMSP_INSTR_RD_BIT   7
`define DIMSP_CFG_ADDR       5'h00
`define DIMSP_CFG_RESET      8'h00
`define DIMSP_CFG_PD_BIT     0
`define DIMSP_CFG_TWOS_BIT   1
`define DIMSP_CFG_DIFF_BIT   2
`endif

// File: hw/dimsp_pkg.sv
package dimsp_pkg;
  typedef logic [11:0] dimsp_word_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_SHIFT,
    HOST_FINISH,
    HOST_GAP
  } dimsp_host_state_e;

  typedef struct packed {
    logic        sel_s1;
    logic        sel_s2;
    logic        sck_s1;
    logic        sck_s2;
    logic        sck_s3;
    logic        cs_s1;
    logic        cs_s2;
    logic        io_s1;
    logic        io_s2;
    dimsp_word_t word;
    dimsp_word_t true_out;
    dimsp_word_t comp_out;
    logic        pd;
    logic        diff;
    logic [7:0]  cfg;
    logic [4:0]  cnt;
    logic [15:0] shreg;
    logic        rd_mode;
    logic [7:0]  rd;
    logic        sdo;
    logic        sdo_oe;
  } dimsp_dev_s;

  typedef struct packed {
    dimsp_host_state_e st;
    logic [7:0]        div;
    logic [4:0]        bitn;
    logic [15:0]       shreg;
    logic              rd;
    logic [7:0]        rdata;
    logic              busy;
    logic              done;
    logic [2:0]        pulse;
    logic              sel;
    logic              csb;
    logic              sclk;
    logic              sdo;
    logic              oe;
    logic              io_s1;
    logic              io_s2;
    dimsp_word_t       word;
  } dimsp_host_s;
endpackage

// File: hw/dimsp_if.sv
`timescale 1ns/100ps
interface dimsp_if;
  logic       interface_select_reset;
  logic       clock_type_select_serial_clock;
  logic       powerdown_chip_select;
  logic       host_io_o;
  logic       host_io_oe;
  logic       dev_io_o;
  logic       dev_io_oe;
  logic       format_select_serial_io;
  logic       data_msb;
  logic [9:0] data_middle_bits;
  logic       data_lsb;

  // resolved shared line, pulled up when nobody drives
  assign format_select_serial_io = host_io_oe ? host_io_o : (dev_io_oe ? dev_io_o : 1'b1);

  modport dev_mp (
    input  interface_select_reset, clock_type_select_serial_clock, powerdown_chip_select,
    input  format_select_serial_io, data_msb, data_middle_bits, data_lsb,
    output dev_io_o, dev_io_oe
  );
  modport host_mp (
    output interface_select_reset, clock_type_select_serial_clock, powerdown_chip_select,
    output host_io_o, host_io_oe, data_msb, data_middle_bits, data_lsb,
    input  format_select_serial_io
  );
endinterface

// File: hw/dimsp_dev.sv
`timescale 1ns/100ps
`include "dimsp_consts.svh"
module dimsp_dev (
  input  wire logic         i_clock,    // conversion clock
  input  wire logic         i_rst,      // async reset, high
  dimsp_if.dev_mp           b,          // pins toward host
  output logic [11:0]       o_true_current_output,  // true output code
  output logic [11:0]       o_complement_current_output,  // complement code
  output logic              o_powered_down,  // powered down
  output logic              o_clock_differential,  // receiver type
  output logic [7:0]        o_cfg       // serial config register
);
  dimsp_pkg::dimsp_dev_s q;
  dimsp_pkg::dimsp_dev_s d;

  function automatic logic [7:0] read_reg(input logic [4:0] addr, input logic [7:0] cfg);
    read_reg = (addr == `DIMSP_CFG_ADDR) ? cfg : 8'h00;
  endfunction

  always_comb begin
    logic                pin_mode;
    logic                twos;
    logic                rise;
    logic                fall;
    logic [15:0]         nsh;
    dimsp_pkg::dimsp_word_t code;
    pin_mode = 1'b0;
    twos     = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    nsh      = 16'h0000;
    code     = 12'h000;
    d = q;
    d.sel_s1 = b.interface_select_reset;
    d.sel_s2 = q.sel_s1;
    d.sck_s1 = b.clock_type_select_serial_clock;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.cs_s1  = b.powerdown_chip_select;
    d.cs_s2  = q.cs_s1;
    d.io_s1  = b.format_select_serial_io;
    d.io_s2  = q.io_s1;
    d.word   = {b.data_msb, b.data_middle_bits, b.data_lsb};
    pin_mode = q.sel_s2;
    rise     = q.sck_s2 & ~q.sck_s3;
    fall     = ~q.sck_s2 & q.sck_s3;
    nsh      = {q.shreg[14:0], q.io_s2};
    if (pin_mode) begin
      d.pd     = q.cs_s2;
      twos     = q.io_s2;
      d.diff   = q.sck_s2;
      d.cfg    = `DIMSP_CFG_RESET;
      d.cnt    = 5'd0;
      d.rd_mode = 1'b0;
      d.sdo_oe = 1'b0;
    end else begin
      d.pd   = q.cfg[`DIMSP_CFG_PD_BIT];
      twos   = q.cfg[`DIMSP_CFG_TWOS_BIT];
      d.diff = q.cfg[`DIMSP_CFG_DIFF_BIT];
      if (q.cs_s2) begin
        d.cnt     = 5'd0;
        d.rd_mode = 1'b0;
        d.sdo_oe  = 1'b0;
      end else if (rise && q.cnt < 5'(`DIMSP_FRAME_BITS)) begin
        d.shreg = nsh;
        d.cnt   = q.cnt + 5'd1;
        if (q.cnt == 5'(`DIMSP_INSTR_BITS - 1)) begin
          d.rd_mode = nsh[`DIMSP_INSTR_RD_BIT];
          d.rd      = read_reg(nsh[4:0], q.cfg);
        end
        if (q.cnt == 5'(`DIMSP_FRAME_BITS - 1) && !q.rd_mode
            && nsh[12:8] == `DIMSP_CFG_ADDR) begin
          d.cfg = nsh[7:0];
        end
      end else if (fall && q.rd_mode) begin
        if (q.cnt == 5'(`DIMSP_INSTR_BITS)) begin
          d.sdo_oe = 1'b1;
          d.sdo    = q.rd[7];
        end else if (q.cnt > 5'(`DIMSP_INSTR_BITS)) begin
          d.rd  = {q.rd[6:0], 1'b0};
          d.sdo = q.rd[6];
        end
      end
    end
    code = twos ? (q.word ^ `DIMSP_TWOS_FLIP) : q.word;
    d.true_out = d.pd ? 12'h000 : code;
    d.comp_out = d.pd ? 12'h000 : ~code;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_true_current_output       = q.true_out;
  assign o_complement_current_output = q.comp_out;
  assign o_powered_down              = q.pd;
  assign o_clock_differential        = q.diff;
  assign o_cfg                       = q.cfg;
  assign b.dev_io_o                  = q.sdo;
  assign b.dev_io_oe                 = q.sdo_oe;
endmodule

// File: hw/dimsp_host.sv
`timescale 1ns/100ps
`include "dimsp_consts.svh"
module dimsp_host (
  input  wire logic         i_clock,    // conversion clock
  input  wire logic         i_rst,      // async reset, high
  dimsp_if.host_mp          b,          // pins toward device
  input  wire logic [11:0]  i_sample,   // sample word
  input  wire logic         i_pin_mode, // 1 pin mode, 0 serial
  input  wire logic         i_pd,       // strap: power down
  input  wire logic         i_twos,     // strap: twos complement
  input  wire logic         i_diff,     // strap: differential clock
  input  wire logic         i_reset_pulse,  // request register reset pulse
  input  wire logic         i_start,    // start serial transfer
  input  wire logic         i_read,     // transfer is a read
  input  wire logic [4:0]   i_addr,     // register address
  input  wire logic [7:0]   i_wdata,    // write data
  output logic              o_busy,     // transfer or pulse running
  output logic              o_done,     // transfer finished, pulse
  output logic [7:0]        o_rdata     // read data
);
  localparam logic [7:0] HALF_M1 = 8'(`DIMSP_SCLK_HALF_CYC - 1);

  dimsp_pkg::dimsp_host_s q;
  dimsp_pkg::dimsp_host_s d;

  always_comb begin
    logic [15:0] nsh;
    logic        tick;
    nsh  = 16'h0000;
    tick = 1'b0;
    d = q;
    d.done  = 1'b0;
    d.io_s1 = b.format_select_serial_io;
    d.io_s2 = q.io_s1;
    d.word  = i_sample;
    if (q.pulse != 3'd0) begin
      d.pulse = q.pulse - 3'd1;
    end else if (i_reset_pulse && q.st == dimsp_pkg::HOST_IDLE) begin
      d.pulse = 3'(`DIMSP_RST_PULSE_CYC);
    end
    d.sel = i_pin_mode | (d.pulse != 3'd0);
    tick  = (q.div == HALF_M1);
    d.div = tick ? 8'd0 : q.div + 8'd1;
    case (q.st)
      dimsp_pkg::HOST_IDLE: begin
        d.div = 8'd0;
        if (i_pin_mode) begin
          d.csb  = i_pd;
          d.sclk = i_diff;
          d.sdo  = i_twos;
          d.oe   = 1'b1;
        end else begin
          d.csb  = 1'b1;
          d.sclk = 1'b0;
          d.oe   = 1'b0;
        end
        if (i_start && !i_pin_mode && q.pulse == 3'd0 && !i_reset_pulse) begin
          nsh     = {i_read, 2'b00, i_addr, i_wdata};
          d.shreg = nsh;
          d.rd    = i_read;
          d.csb   = 1'b0;
          d.sclk  = 1'b0;
          d.sdo   = nsh[15];
          d.oe    = 1'b1;
          d.bitn  = 5'd0;
          d.busy  = 1'b1;
          d.st    = dimsp_pkg::HOST_SHIFT;
        end
      end
      dimsp_pkg::HOST_SHIFT: begin
        if (tick) begin
          if (!q.sclk) begin
            d.sclk = 1'b1;
            if (q.rd && q.bitn >= 5'(`DIMSP_INSTR_BITS)) begin
              d.rdata = {q.rdata[6:0], q.io_s2};
            end
          end else begin
            d.sclk = 1'b0;
            d.bitn = q.bitn + 5'd1;
            if (q.bitn == 5'(`DIMSP_FRAME_BITS - 1)) begin
              d.oe = 1'b0;
              d.st = dimsp_pkg::HOST_FINISH;
            end else begin
              nsh     = {q.shreg[14:0], 1'b0};
              d.shreg = nsh;
              d.sdo   = nsh[15];
              d.oe    = !(q.rd && q.bitn >= 5'(`DIMSP_INSTR_BITS - 1));
            end
          end
        end
      end
      dimsp_pkg::HOST_FINISH: begin
        if (tick) begin
          d.csb = 1'b1;
          d.st  = dimsp_pkg::HOST_GAP;
        end
      end
      dimsp_pkg::HOST_GAP: begin
        // gap lets the device see chip select high
        if (tick) begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st   = dimsp_pkg::HOST_IDLE;
        end
      end
      default: begin
        d.st = dimsp_pkg::HOST_IDLE;
      end
    endcase
    if (d.pulse != 3'd0) begin
      d.busy = 1'b1;
    end else if (q.pulse != 3'd0 && q.st == dimsp_pkg::HOST_IDLE) begin
      d.busy = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q      <= '0;
      q.sel  <= 1'b1;
      q.csb  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign b.interface_select_reset         = q.sel;
  assign b.clock_type_select_serial_clock = q.sclk;
  assign b.powerdown_chip_select          = q.csb;
  assign b.host_io_o                      = q.sdo;
  assign b.host_io_oe                     = q.oe;
  assign b.data_msb                       = q.word[11];
  assign b.data_middle_bits               = q.word[10:1];
  assign b.data_lsb                       = q.word[0];
  assign o_busy                           = q.busy;
  assign o_done                           = q.done;
  assign o_rdata                          = q.rdata;
endmodule

// File: test/dimsp_props.sv
`timescale 1ns/100ps
module dimsp_props (
  input wire logic i_clock,                        // conversion clock
  input wire logic i_rst,                          // async reset, high
  input wire logic interface_select_reset,         // mode select
  input wire logic clock_type_select_serial_clock, // strap or serial clock
  input wire logic powerdown_chip_select,          // strap or chip select
  input wire logic host_io_oe,                     // host drives line
  input wire logic dev_io_oe                       // device drives line
);
  wire s = interface_select_reset;
  wire k = clock_type_select_serial_clock;
  wire c = powerdown_chip_select;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sclk_in_frame_a: assert property (
    $rose(k) && !s |-> !c) else $error("serial clock rose outside frame");
  sclk_high_time_a: assert property (
    $rose(k) && !s |-> k [*8] ##1 !k) else $error("serial clock high time off");
  sclk_idle_a: assert property (
    !s && !$past(s) && c |-> !k) else $error("serial clock not idle low");
  frame_start_a: assert property (
    $fell(c) && !s |-> host_io_oe) else $error("frame began without host drive");
  dev_release_a: assert property (
    $rose(c) && !s |-> ##[1:4] !dev_io_oe) else $error("device kept line after frame");
  no_contention_a: assert property (
    !(host_io_oe && dev_io_oe)) else $error("both ends drive the line");
  pin_mode_quiet_a: assert property (
    s [*4] |-> !dev_io_oe) else $error("device drove line in pin mode");
  mode_hold_a: assert property (
    !c && !s |=> !s) else $error("mode changed inside frame");
endmodule

// File: test/dimsp_tb.sv
`timescale 1ns/100ps
module dimsp_tb;
  logic        i_clock;
  logic        i_rst;
  logic [11:0] i_sample, s, w, tout, cout;
  logic        pin, pd, twos, diff, rpulse, start, rd, done, pdn, dif, busy;
  logic [4:0]  addr;
  logic [7:0]  wdata, rdata, cfg, v;
  logic [15:0] rnd;
  logic [8:0]  exp_q[$];
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          n;
  int          nb;
  dimsp_if i_dimsp_if ();
  dimsp_dev i_dimsp_dev (.i_clock(i_clock), .i_rst(i_rst), .b(i_dimsp_if),
    .o_true_current_output(tout), .o_complement_current_output(cout),
    .o_powered_down(pdn), .o_clock_differential(dif), .o_cfg(cfg));
  dimsp_host i_dimsp_host (.i_clock(i_clock), .i_rst(i_rst), .b(i_dimsp_if),
    .i_sample(i_sample), .i_pin_mode(pin), .i_pd(pd), .i_twos(twos), .i_diff(diff),
    .i_reset_pulse(rpulse), .i_start(start), .i_read(rd), .i_addr(addr),
    .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata));
  dimsp_props i_dimsp_props (.i_clock(i_clock), .i_rst(i_rst),
    .interface_select_reset(i_dimsp_if.interface_select_reset),
    .clock_type_select_serial_clock(i_dimsp_if.clock_type_select_serial_clock),
    .powerdown_chip_select(i_dimsp_if.powerdown_chip_select),
    .host_io_oe(i_dimsp_if.host_io_oe), .dev_io_oe(i_dimsp_if.dev_io_oe));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // every transfer leaves a note; only reads carry a value to compare
  task automatic xfer(input logic r, input logic [4:0] a, input logic [7:0] d);
    int t;
    @(posedge i_clock);
    start <= 1'b1;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    start <= 1'b0;
    exp_q.push_back({r, v});
    t = 0;
    while (done !== 1'b1 && t < 400) begin
      @(negedge i_clock);
      t++;
    end
    // a hung frame ends the run at once
    if (t == 400) begin
      miscompares++;
      stop_test();
    end
  endtask

  always @(negedge i_clock) begin
    if (done === 1'b1 && exp_q.size() > 0) begin
      if (exp_q[0][8]) check(12'(rdata), 12'(exp_q[0][7:0]));
      void'(exp_q.pop_front());
    end
  end

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  initial begin
    i_rst = 1'b1;
    i_sample = 12'h000;
    pin = 1'b1;
    {pd, twos, diff, rpulse, start, rd} = 6'h00;
    addr = 5'h00;
    wdata = 8'h00;
    v = 8'h00;
    rnd = 16'haa50;
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int m = 0; m < 7; m++) begin
      rnd = lfsr(rnd);
      s = (m % 3 == 0) ? 12'hfff : (m % 3 == 1) ? 12'h000 : rnd[11:0];
      @(posedge i_clock);
      i_sample <= s;
      twos <= (m >= 3);
      diff <= rnd[12];
      pd <= (m == 6);
      repeat (6) @(negedge i_clock);
      w = (m == 6) ? 12'h000 : s ^ ((m >= 3) ? 12'h800 : 12'h000);
      check({i_dimsp_if.data_msb, i_dimsp_if.data_middle_bits, i_dimsp_if.data_lsb}, s);
      check(tout, w);
      check(cout, (m == 6) ? 12'h000 : ~w);
      check(12'(dif), 12'(rnd[12]));
      check(12'(pdn), 12'(m == 6));
    end
    $display("pin mode test ended");
    @(posedge i_clock);
    pin <= 1'b0;
    pd <= 1'b0;
    repeat (4) @(posedge i_clock);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      v = (k == 0) ? 8'h07 : (k == 1) ? 8'h02 : {5'h00, rnd[2:0]};
      xfer(1'b0, 5'h00, v);
      xfer(1'b1, 5'h00, 8'h00);
      check(12'(cfg), 12'(v));
      check(12'(pdn), 12'(v[0]));
      check(12'(dif), 12'(v[2]));
      check(12'(busy), 12'h000);
      check(tout, v[0] ? 12'h000 : s ^ (v[1] ? 12'h800 : 12'h000));
    end
    xfer(1'b0, 5'h03, 8'h05);
    check(12'(cfg), 12'(v));
    v = 8'h00;
    xfer(1'b1, 5'h03, 8'h00);
    // nonzero config so the reset pulse has something to clear
    xfer(1'b0, 5'h00, 8'h06);
    check(12'(cfg), 12'h006);
    $display("serial test ended");
    @(posedge i_clock);
    rpulse <= 1'b1;
    @(posedge i_clock);
    rpulse <= 1'b0;
    n = 0;
    nb = 0;
    repeat (10) begin
      @(negedge i_clock);
      n += i_dimsp_if.interface_select_reset;
      nb += busy;
    end
    check(12'(n), 12'h004);
    check(12'(nb), 12'h004);
    check(12'(cfg), 12'h000);
    xfer(1'b1, 5'h00, 8'h00);
    $display("register reset test ended");
    repeat (4) @(posedge i_clock);
    // every note must have met its result
    check(12'(exp_q.size()), 12'h000);
    stop_test();
  end
endmodule
